/* core/agu_pkg.sv */
package agu_pkg;

   // ----------------------------------------
   // register map (byte addresses, one word each)
   // ----------------------------------------
   localparam logic [7:0] ADDR_SP = 8'h00;
   localparam logic [7:0] ADDR_LIMIT = 8'h04;
   localparam logic [7:0] ADDR_TBLPAGE = 8'h08;
   localparam logic [7:0] ADDR_WINPAGE = 8'h0C;
   localparam logic [7:0] ADDR_CORE_CTL = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_STAT_LO = 8'h18;

   // ----------------------------------------
   // field positions and fixed values
   // ----------------------------------------
   localparam int CTL_WIN_EN_BIT = 2;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_UNF_BIT = 1;
   localparam int STAT_STALL_BIT = 2;
   localparam int PAGE_SPACE_BIT = 7;
   localparam int EA_MSB = 15;
   localparam logic [15:0] STACK_FLOOR = 16'h0800;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] SP_RESET = 16'h0800;
   localparam logic [7:0] WINPAGE_PROG = 8'h00;
   localparam logic [7:0] WINPAGE_EEPROM = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int WIN_EXTRA_CYCLES = 1;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef enum logic [1:0] {
      STK_NONE,
      STK_PUSH,
      STK_POP
   } stack_op_e;

   typedef struct packed {
      logic valid;          // request strobe
      stack_op_e op;        // push or pop
      logic is_call;        // call return-address push
      logic is_exc;         // exception return-address push
      logic [23:0] pc;      // program counter to push
   } stack_req_s;

   typedef struct packed {
      logic valid;          // request strobe
      logic [15:0] ea;      // data effective address
      logic is_table;       // table op rather than plain data
      logic is_write;       // table or window write
   } data_req_s;

   typedef struct packed {
      logic valid;          // address produced
      logic [23:0] paddr;   // program address
      logic to_prog;        // targets program space
      logic config_space;   // configuration space
      logic [15:0] daddr;   // pass-through data address
      logic stall;          // one extra cycle for window read
      logic fault;          // table write to config or window write refused
   } addr_resp_s;

endpackage : agu_pkg

/* core/stack_check_and_progspace_agu.sv */
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - sp holds next free word, grows up
// - push writes then increments, pop decrements first
// - call pushes zero-extended return high byte
// - exception push joins status byte with pc
// - limit unreset, bit zero forced low
// - every push ea compared with limit
// - push at limit ok, next push traps
// - stack ea below floor raises underflow trap
// - table address is page over full ea
// - page top bit picks user or config
// - window address is page over ea[14:0]
// - window always user space, bit 23 zero
// - window bit 15 from page bit 0
// - window page only all zeros or ones
// - window address lsb forced zero
// - table addresses need no word alignment
// - table reads may reach config space
// - window read-only, low word only
// - table reads reach every program byte
// - window needs ea msb and enable bit
// - window read adds one stall cycle
module stack_check_and_progspace_agu (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // stack requests from core
   input wire agu_pkg::stack_req_s stack_req,
   // stack memory access
   output logic stack_mem_valid,
   output logic stack_mem_write,
   output logic [15:0] stack_mem_addr,
   output logic [15:0] stack_mem_wdata_lo,
   output logic [15:0] stack_mem_wdata_hi,
   output logic stack_trap,
   // data/table address requests from core
   input wire agu_pkg::data_req_s data_req,
   output agu_pkg::addr_resp_s addr_resp
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   // software-visible registers
   logic [15:0] sp_r;          // stack pointer
   logic [15:0] limit_r;       // stack limit
   logic [7:0] tblpage_r;      // table page
   logic [7:0] winpage_r;      // window page
   logic win_en_r;             // window enable
   logic [7:0] stat_lo_r;      // status low byte
   // error flags, bus bookkeeping and stack decode
   logic ovf_r;                // overflow seen
   logic unf_r;                // underflow seen
   logic aw_hold_r;            // write address latched
   logic w_hold_r;             // write data latched
   logic [7:0] awaddr_r;       // latched write address
   logic [31:0] wdata_r;       // latched write data
   logic [3:0] wstrb_r;        // latched strobes
   logic [15:0] sp_nxt;        // next stack pointer
   logic [15:0] stk_ea;        // effective stack address
   logic push_ev;              // push taken
   logic pop_ev;               // pop taken
   logic ovf_hit;              // overflow this request
   logic unf_hit;              // underflow this request
   logic wr_fire;              // register write executes
   logic sw_sp_wr;             // software writes sp

   // merge a 16-bit field under byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // ----------------------------------------
   // stack address and checks
   // ----------------------------------------
   // decode the core's stack strobe
   assign push_ev = stack_req.valid && (stack_req.op == agu_pkg::STK_PUSH);
   assign pop_ev = stack_req.valid && (stack_req.op == agu_pkg::STK_POP);

   // push uses sp as is, pop uses pre-decremented sp
   always_comb begin
      stk_ea = sp_r;
      sp_nxt = sp_r;
      if (push_ev) begin
         stk_ea = sp_r;
         sp_nxt = sp_r + agu_pkg::WORD_STEP;
      end else if (pop_ev) begin
         stk_ea = sp_r - agu_pkg::WORD_STEP;
         sp_nxt = stk_ea;
      end
   end

   // limit compared against stack ea; equality still allowed
   // pops move away from the limit, so only pushes count
   assign ovf_hit = push_ev && (stk_ea > limit_r);
   // underflow below the register-file floor
   assign unf_hit = stack_req.valid && (stk_ea < agu_pkg::STACK_FLOOR);

   // stack memory strobe and return-address formatting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_mem_valid <= 1'b0;
         stack_mem_write <= 1'b0;
         stack_mem_addr <= 16'h0000;
         stack_mem_wdata_lo <= 16'h0000;
         stack_mem_wdata_hi <= 16'h0000;
      end else begin
         stack_mem_valid <= (push_ev || pop_ev) && !ovf_hit && !unf_hit;
         stack_mem_write <= push_ev;
         stack_mem_addr <= stk_ea;
         stack_mem_wdata_lo <= stack_req.pc[15:0];
         // top byte: status byte or zero
         if (stack_req.is_exc) begin
            stack_mem_wdata_hi <= {stat_lo_r, stack_req.pc[23:16]};
         end else begin
            stack_mem_wdata_hi <= {8'h00, stack_req.pc[23:16]};
         end
      end
   end

   // trap pulse one cycle after a failed check
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_trap <= 1'b0;
      end else begin
         stack_trap <= ovf_hit || unf_hit;
      end
   end

   // stack pointer; faulting ops leave it alone, software wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_r <= agu_pkg::SP_RESET;
      end else if (sw_sp_wr) begin
         sp_r <= merge16(sp_r, wdata_r, wstrb_r) & ~16'h0001;
      end else if ((push_ev || pop_ev) && !ovf_hit && !unf_hit) begin
         sp_r <= sp_nxt;
      end
   end

   // sticky error flags; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
      end else begin
         // write one to clear, events then set
         if (wr_fire && awaddr_r == agu_pkg::ADDR_STATUS && wstrb_r[0]) begin
            if (wdata_r[agu_pkg::STAT_OVF_BIT]) ovf_r <= 1'b0;
            if (wdata_r[agu_pkg::STAT_UNF_BIT]) unf_r <= 1'b0;
         end
         if (ovf_hit) ovf_r <= 1'b1;
         if (unf_hit) unf_r <= 1'b1;
      end
   end

   // limit register: no reset value, bit zero always low
   // unknown until software writes it
   always_ff @(posedge aclk) begin
      if (wr_fire && awaddr_r == agu_pkg::ADDR_LIMIT) begin
         limit_r <= merge16(limit_r, wdata_r, wstrb_r) & ~16'h0001;
      end
   end

   // ----------------------------------------
   // program-space address generation
   // ----------------------------------------
   logic win_hit;              // window access selected
   logic win_stall_r;          // second fetch cycle pending
   assign win_hit = win_en_r && data_req.ea[agu_pkg::EA_MSB] && !data_req.is_table;

   // address former, registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_resp <= '0;
         win_stall_r <= 1'b0;
      end else begin
         // strobes last one cycle; a request
         // during the second window fetch is dropped
         addr_resp.valid <= data_req.valid && !win_stall_r;
         addr_resp.stall <= 1'b0;
         addr_resp.fault <= 1'b0;
         win_stall_r <= 1'b0;
         if (win_stall_r) begin
            // second fetch of window read
            addr_resp.valid <= 1'b1;
         end else if (data_req.valid && data_req.is_table) begin
            // full page over unaligned ea
            addr_resp.paddr <= {tblpage_r, data_req.ea};
            addr_resp.to_prog <= 1'b1;
            addr_resp.config_space <= tblpage_r[agu_pkg::PAGE_SPACE_BIT];
            addr_resp.fault <= data_req.is_write && tblpage_r[agu_pkg::PAGE_SPACE_BIT];
            addr_resp.daddr <= data_req.ea;
         end else if (data_req.valid && win_hit) begin
            // user space only, ea bit 15 dropped, lsb low
            addr_resp.paddr <= {1'b0, winpage_r, data_req.ea[14:1], 1'b0};
            addr_resp.to_prog <= 1'b1;
            addr_resp.config_space <= 1'b0;
            addr_resp.fault <= data_req.is_write;
            addr_resp.stall <= !data_req.is_write;
            win_stall_r <= !data_req.is_write;
            addr_resp.daddr <= data_req.ea;
         end else if (data_req.valid) begin
            // plain data access, no program address
            addr_resp.paddr <= 24'h000000;
            addr_resp.to_prog <= 1'b0;
            addr_resp.config_space <= 1'b0;
            addr_resp.daddr <= data_req.ea;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   // one write in flight; bvalid holds off the next
   assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign sw_sp_wr = wr_fire && awaddr_r == agu_pkg::ADDR_SP;

   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         // ready pulses while idle
         s_axi_awready <= !aw_hold_r && !s_axi_awready;
         s_axi_wready <= !w_hold_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= agu_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         unique case (awaddr_r)
            // every mapped offset answers okay
            agu_pkg::ADDR_SP, agu_pkg::ADDR_LIMIT, agu_pkg::ADDR_TBLPAGE, agu_pkg::ADDR_WINPAGE,
            agu_pkg::ADDR_CORE_CTL, agu_pkg::ADDR_STATUS, agu_pkg::ADDR_STAT_LO: begin
               s_axi_bresp <= agu_pkg::RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= agu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // writable control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tblpage_r <= 8'h00;
         winpage_r <= agu_pkg::WINPAGE_PROG;
         win_en_r <= 1'b0;
         stat_lo_r <= 8'h00;
      end else if (wr_fire && wstrb_r[0]) begin
         // only byte lane zero carries these
         unique case (awaddr_r)
            agu_pkg::ADDR_TBLPAGE: begin
               tblpage_r <= wdata_r[7:0];
            end
            agu_pkg::ADDR_WINPAGE: begin
               // any nonzero value selects the eeprom page
               winpage_r <= (wdata_r[7:0] == agu_pkg::WINPAGE_PROG) ? agu_pkg::WINPAGE_PROG
                                                                    : agu_pkg::WINPAGE_EEPROM;
            end
            agu_pkg::ADDR_CORE_CTL: begin
               win_en_r <= wdata_r[agu_pkg::CTL_WIN_EN_BIT];
            end
            agu_pkg::ADDR_STAT_LO: begin
               // byte paired with an exception return address
               stat_lo_r <= wdata_r[7:0];
            end
            default: begin
               // sp, limit and status have their own processes
            end
         endcase
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   // one read at a time, decoded at handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= agu_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= agu_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
               agu_pkg::ADDR_SP: s_axi_rdata <= {16'h0000, sp_r};
               // upper bits read as zero
               agu_pkg::ADDR_LIMIT: s_axi_rdata <= {16'h0000, limit_r};
               agu_pkg::ADDR_TBLPAGE: s_axi_rdata <= {24'h000000, tblpage_r};
               agu_pkg::ADDR_WINPAGE: s_axi_rdata <= {24'h000000, winpage_r};
               agu_pkg::ADDR_CORE_CTL: s_axi_rdata <= {29'h0000000, win_en_r, 2'h0};
               agu_pkg::ADDR_STATUS: s_axi_rdata <= {29'h0000000, win_stall_r, unf_r, ovf_r};
               agu_pkg::ADDR_STAT_LO: s_axi_rdata <= {24'h000000, stat_lo_r};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= agu_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : stack_check_and_progspace_agu

`default_nettype wire

/* dv/agu_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// stack and address relations
// ------------------------------
module agu_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // stack side
   input wire agu_pkg::stack_req_s stack_req,
   input wire logic stack_mem_valid,
   input wire logic stack_mem_write,
   input wire logic [15:0] stack_mem_addr,
   input wire logic [15:0] stack_mem_wdata_hi,
   input wire logic stack_trap,
   // address side
   input wire agu_pkg::data_req_s data_req,
   input wire agu_pkg::addr_resp_s addr_resp
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic push_now; // push requested this edge
   logic mem_push; // memory write strobe
   assign push_now = stack_req.valid && stack_req.op == agu_pkg::STK_PUSH;
   assign mem_push = stack_mem_valid && stack_mem_write;
   property p_push_ans; push_now |=> mem_push || stack_trap; endproperty
   a_push_ans: assert property (p_push_ans) else $error("push unanswered");
   property p_push_step;
      $past(mem_push) && mem_push |-> stack_mem_addr == $past(stack_mem_addr) + agu_pkg::WORD_STEP;
   endproperty
   a_push_step: assert property (p_push_step) else $error("push step wrong");
   property p_pop_back;
      $past(mem_push) && stack_mem_valid && !stack_mem_write |-> stack_mem_addr == $past(stack_mem_addr);
   endproperty
   a_pop_back: assert property (p_pop_back) else $error("pop address wrong");
   property p_call_hi; push_now && stack_req.is_call |=> stack_trap || stack_mem_wdata_hi[15:8] == 8'h00; endproperty
   a_call_hi: assert property (p_call_hi) else $error("call high byte set");
   property p_exc_hi;
      push_now && stack_req.is_exc |=> stack_trap || stack_mem_wdata_hi[7:0] == $past(stack_req.pc[23:16]);
   endproperty
   a_exc_hi: assert property (p_exc_hi) else $error("exception word wrong");
   property p_floor; stack_mem_valid |-> stack_mem_addr >= agu_pkg::STACK_FLOOR; endproperty
   a_floor: assert property (p_floor) else $error("access below floor");
   property p_trap_cause; stack_trap |-> !stack_mem_valid && $past(stack_req.valid); endproperty
   a_trap_cause: assert property (p_trap_cause) else $error("trap without op");
   property p_tbl_addr;
      $past(data_req.valid && data_req.is_table) |-> addr_resp.valid && addr_resp.to_prog &&
         addr_resp.paddr[15:0] == $past(data_req.ea) && addr_resp.config_space == addr_resp.paddr[23];
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
   property p_win_addr;
      $past(data_req.valid && !data_req.is_table) && addr_resp.to_prog |-> !addr_resp.paddr[23] &&
         !addr_resp.paddr[0] && addr_resp.paddr[22:15] inside {8'h00, 8'hFF} &&
         addr_resp.paddr[14:1] == $past(data_req.ea[14:1]);
   endproperty
   a_win_addr: assert property (p_win_addr) else $error("window address wrong");
   property p_win_stall;
      addr_resp.valid && addr_resp.stall |=> addr_resp.valid && !addr_resp.stall && $stable(addr_resp.paddr);
   endproperty
   a_win_stall: assert property (p_win_stall) else $error("stall not one cycle");
   property p_pass;
      $past(data_req.valid && !data_req.is_table && !data_req.ea[15]) |-> addr_resp.valid &&
         !addr_resp.to_prog && addr_resp.daddr == $past(data_req.ea);
   endproperty
   a_pass: assert property (p_pass) else $error("pass-through wrong");
endmodule : agu_assertions

bind stack_check_and_progspace_agu agu_assertions u_agu_chk (
   .aclk, .aresetn, .stack_req, .stack_mem_valid, .stack_mem_write, .stack_mem_addr,
   .stack_mem_wdata_hi, .stack_trap, .data_req, .addr_resp
);
`default_nettype wire

/* dv/stack_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// stack memory beside the core
// ------------------------------
module stack_mem_model (
   // clock
   input wire logic aclk,
   // stack memory port
   input wire logic stack_mem_valid,
   input wire logic stack_mem_write,
   input wire logic [15:0] stack_mem_addr,
   input wire logic [15:0] stack_mem_wdata_lo,
   input wire logic [15:0] stack_mem_wdata_hi,
   // pop of a word never pushed
   output logic bad_pop
);
   logic [31:0] mem [logic [15:0]]; // sparse word store
   initial bad_pop = 1'b0;
   // store pushes, flag pops of empty words
   always @(posedge aclk) begin
      bad_pop <= 1'b0;
      if (stack_mem_valid === 1'b1) begin
         if (stack_mem_write) mem[stack_mem_addr] = {stack_mem_wdata_hi, stack_mem_wdata_lo};
         else bad_pop <= !mem.exists(stack_mem_addr);
      end
   end
endmodule : stack_mem_model
`default_nettype wire

/* dv/test_stack_check_and_progspace_agu.sv */
`timescale 1ns/1ps
`default_nettype none
module test_stack_check_and_progspace_agu;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   agu_pkg::stack_req_s stack_req;
   agu_pkg::data_req_s data_req;
   agu_pkg::addr_resp_s addr_resp;
   logic stack_mem_valid, stack_mem_write, stack_trap, bad_pop, en_m;
   logic [15:0] stack_mem_addr, stack_mem_wdata_lo, stack_mem_wdata_hi, sp_m, lim_m;
   logic [7:0] tp_m, wp_m, wv, stat_lo_m;
   logic [55:0] exp_q[$]; // expected results, oldest first
   int num_errors, n_tests, seed;
   stack_check_and_progspace_agu DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .stack_req, .stack_mem_valid, .stack_mem_write, .stack_mem_addr, .stack_mem_wdata_lo,
      .stack_mem_wdata_hi, .stack_trap, .data_req, .addr_resp);
   stack_mem_model u_mem (.aclk, .stack_mem_valid, .stack_mem_write, .stack_mem_addr,
      .stack_mem_wdata_lo, .stack_mem_wdata_hi, .bad_pop);
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic bad(input string n, input logic [55:0] e, input logic [55:0] s);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : bad
   // oldest note against a seen result, every field
   task automatic chk(input logic [55:0] s);
      logic [55:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 56'h0;
      bad("result", e, s);
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      bad("bresp", 56'(agu_pkg::RESP_OKAY), 56'(s_axi_bresp));
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      bad("read", {22'h0, er, ed}, {22'h0, s_axi_rresp, s_axi_rdata});
   endtask : axi_rd
   // one stack op, expectation from the limit and floor
   task automatic stk(input agu_pkg::stack_op_e op, input logic call, input logic exc);
      logic [23:0] pc;
      logic [15:0] a;
      pc = 24'($random(seed));
      a = (op == agu_pkg::STK_PUSH) ? sp_m : sp_m - agu_pkg::WORD_STEP;
      stack_req <= '{1'b1, op, call, exc, pc};
      if (a < agu_pkg::STACK_FLOOR || (op == agu_pkg::STK_PUSH && a > lim_m)) exp_q.push_back({8'h02, 48'h0});
      else if (op == agu_pkg::STK_PUSH) begin
         exp_q.push_back({8'h01, a, exc ? stat_lo_m : 8'h00, pc});
         sp_m = a + agu_pkg::WORD_STEP;
      end else begin
         exp_q.push_back({8'h04, a, 32'h0});
         sp_m = a;
      end
      @(posedge aclk);
   endtask : stk
   // one address request, expectation from pages and enable
   task automatic adr(input logic [15:0] ea, input logic tbl, input logic wr);
      logic [55:0] e;
      data_req <= '{1'b1, ea, tbl, wr};
      if (tbl) exp_q.push_back({8'h03, tp_m, ea, 1'b1, tp_m[7], 1'b0, wr & tp_m[7], 4'h0, ea});
      else if (ea[15] && en_m) begin
         // window writes fault at once, reads take a second cycle
         e = {8'h03, 1'b0, wp_m, ea[14:1], 1'b0, 2'b10, !wr, wr, 4'h0, ea};
         exp_q.push_back(e);
         e[21] = 1'b0;
         if (!wr) exp_q.push_back(e);
      end else exp_q.push_back({8'h03, 24'h0, 8'h00, ea});
      @(posedge aclk);
      data_req.valid <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : adr
   // ------------------------------
   // clock, monitor, watchdog
   // ------------------------------
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (stack_mem_valid === 1'b1) chk(stack_mem_write ? {8'h01, stack_mem_addr, stack_mem_wdata_hi,
         stack_mem_wdata_lo} : {8'h04, stack_mem_addr, 32'h0});
      if (stack_trap === 1'b1) chk({8'h02, 48'h0});
      if (addr_resp.valid === 1'b1) chk({8'h03, addr_resp.paddr, addr_resp.to_prog, addr_resp.config_space,
         addr_resp.stall, addr_resp.fault, 4'h0, addr_resp.daddr});
      if (bad_pop === 1'b1) bad("pop", 56'h0, 56'h1);
   end
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      seed = 34;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      stack_req = '0;
      data_req = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      sp_m = agu_pkg::SP_RESET;
      lim_m = 16'h0804;
      axi_rd(agu_pkg::ADDR_SP, 32'h0800, agu_pkg::RESP_OKAY);
      axi_wr(agu_pkg::ADDR_LIMIT, 32'h0805);
      axi_rd(agu_pkg::ADDR_LIMIT, 32'h0804, agu_pkg::RESP_OKAY);
      axi_rd(8'h1C, 32'h0, agu_pkg::RESP_SLVERR);
      stat_lo_m = 8'($random(seed));
      axi_wr(agu_pkg::ADDR_STAT_LO, {24'h0, stat_lo_m});
      @(posedge aclk);
      stk(agu_pkg::STK_PUSH, 1'b1, 1'b0);
      stk(agu_pkg::STK_PUSH, 1'b0, 1'b1);
      stk(agu_pkg::STK_PUSH, 1'b1, 1'b0);
      stk(agu_pkg::STK_PUSH, 1'b1, 1'b0);
      repeat (4) stk(agu_pkg::STK_POP, 1'b0, 1'b0);
      stk(agu_pkg::STK_PUSH, 1'b1, 1'b0);
      stk(agu_pkg::STK_POP, 1'b0, 1'b0);
      stack_req.valid <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(agu_pkg::ADDR_STATUS, 32'h3, agu_pkg::RESP_OKAY);
      axi_wr(agu_pkg::ADDR_STATUS, 32'h3);
      axi_rd(agu_pkg::ADDR_STATUS, 32'h0, agu_pkg::RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         tp_m = {i[0] ^ i[1], r[6:0]};
         wv = i[1] ? 8'h00 : (r[15:8] | 8'h01);
         wp_m = (wv == 8'h00) ? agu_pkg::WINPAGE_PROG : agu_pkg::WINPAGE_EEPROM;
         en_m = i[0];
         axi_wr(agu_pkg::ADDR_TBLPAGE, {24'h0, tp_m});
         axi_wr(agu_pkg::ADDR_WINPAGE, {24'h0, wv});
         axi_wr(agu_pkg::ADDR_CORE_CTL, {29'h0, en_m, 2'b00});
         for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            r[16:15] = r[16:15] | 2'(k);
            adr(r[15:0], r[16], r[17]);
         end
      end
      repeat (3) @(posedge aclk);
      if (exp_q.size() != 0) bad("left", 56'h0, 56'(exp_q.size()));
      conclude();
   end
endmodule : test_stack_check_and_progspace_agu
`default_nettype wire
